//--- inc/tcc_map.svh
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define TCC_CTL_BASE 8'h00
`define TCC_CCR_BASE 8'h10
`define TCC_IV_ADDR 8'h20
`define TCC_OVF_ADDR 8'h22
`define TCC_STRIDE 8'h02
// ****************************************
// channel control fields
// ****************************************
`define TCC_F_FLAG 0
`define TCC_F_COV 1
`define TCC_F_OUT 2
`define TCC_F_LVL 3
`define TCC_F_IE 4
`define TCC_F_MODE 5
`define TCC_F_CAP 8
`define TCC_F_LATCH 10
`define TCC_F_SCS 11
`define TCC_F_INSEL 12
`define TCC_F_EDGE 14
// overflow control fields
`define TCC_F_OVF_FLAG 0
`define TCC_F_OVF_IE 1
// ****************************************
// encodings
// ****************************************
`define TCC_EDGE_RISE 2'h1
`define TCC_EDGE_FALL 2'h2
`define TCC_EDGE_BOTH 2'h3
`define TCC_SEL_A 2'h0
`define TCC_SEL_B 2'h1
`define TCC_SEL_LOW 2'h2
`define TCC_SEL_HIGH 2'h3
`define TCC_OM_OUTBIT 3'h0
`define TCC_OM_SET 3'h1
`define TCC_OM_TOG_RST 3'h2
`define TCC_OM_SET_RST 3'h3
`define TCC_OM_TOGGLE 3'h4
`define TCC_OM_RESET 3'h5
`define TCC_OM_TOG_SET 3'h6
`define TCC_OM_RST_SET 3'h7
`define TCC_IV_NONE 16'h0000
`define TCC_IV_OVF 16'h000a
// ****************************************
// reset values
// ****************************************
`define TCC_RST_WORD 16'h0000
`endif

//--- inc/tcc_pkg.sv
`default_nettype none
package tcc_pkg;
	// one capture/compare channel
	typedef struct packed {
		logic [1:0] edge_sel;
		logic [1:0] in_sel;
		logic scs;
		logic latched;
		logic cap;
		logic [2:0] mode;
		logic ie;
		logic out;
		logic cov;
		logic flag;
		logic [15:0] ccr;
		logic unread;
		logic prev_src;
		logic pend;
		logic [2:0] sync_a;
		logic [2:0] sync_b;
		logic filt_a;
		logic filt_b;
	} tcc_ch_t;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} tcc_bus_t;
endpackage : tcc_pkg
`default_nettype wire

//--- rtl/tcc_top.sv
// Contract
// - capture_select 1 selects capture mode, 0 selects compare mode
// - capture source from input_a or input_b; edge select rising/falling/both
// - input_select 00 a, 01 b, 10 constant low, 11 constant high
// - selected edge copies timer_count to channel_register, sets channel_flag
// - input_level reads current selected source level in every mode
// - sync_capture delays capture by one I_REF_CLK cycle, whether or not I_COUNT_TICK is set
// - capture_overrun set on second unread capture, cleared by software only
// - toggling input_select_bit0 with both edges captures on each change
// - compare match sets flag, pulses channel_match, drives output, latches level
// - channel_register writes take effect at once, no buffering
// - channel_output changes on rising clock edge in modes 1 to 7
// - mode 000 output follows software output bit
// - mode 001 sets output on channel match
// - mode 010 toggle/clear, mode 011 set/clear on channel/period match
// - mode 110 toggle/set, mode 111 clear/set on channel/period match
// - mode 100 toggles output on every channel match
// - mode 101 clears output on channel match
// - matches act on equality in either count direction
// - software may set or clear flags; irq needs channel and global enable
// - channel 0 flag has own request, cleared when serviced
// - vector shows highest enabled pending source only
// - vector codes 00 none, 02..08 channels 1..4, 0a overflow
// - any vector access clears highest pending flag
`timescale 1ns/10ps
`default_nettype none
`include "tcc_map.svh"
module tcc_top #(
	parameter int NCH = 5
) (
	// clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_RESETN,
	// register port
	input wire logic [7:0] I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [15:0] O_RDATA,
	// timer counter side
	input wire logic [15:0] I_TIMER_COUNT,
	input wire logic I_COUNT_TICK,
	input wire logic I_OVERFLOW,
	// interrupt side
	input wire logic I_GLOBAL_IRQ_EN,
	input wire logic I_CH0_ACK,
	output logic O_IRQ_CH0,
	output logic O_IRQ_VEC,
	// capture inputs
	input wire logic [NCH-1:0] I_INPUT_A,
	input wire logic [NCH-1:0] I_INPUT_B,
	// channel outputs
	output logic [NCH-1:0] O_CH_OUT,
	output logic [NCH-1:0] O_CH_MATCH,
	output logic O_PERIOD_MATCH
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		tcc_pkg::tcc_ch_t [NCH-1:0] ch;
		logic ovf_flag;
		logic ovf_ie;
		logic [15:0] rdata;
		logic irq0;
		logic irqv;
		logic [NCH-1:0] match;
		logic pmatch;
	} tcc_state_t;

	tcc_state_t state_reg;
	tcc_state_t state_next;
	tcc_pkg::tcc_bus_t bus;
	logic [1:0] rst_sync_reg;
	logic rst_n;

	// bus request bundle
	assign bus.addr = I_ADDR;
	assign bus.wdata = I_WDATA;
	assign bus.wr = I_WR;
	assign bus.rd = I_RD;

	// ****************************************
	// functions
	// ****************************************

	// highest enabled pending vector code
	function automatic logic [15:0] vec_code(
		input logic [NCH-1:0] pf,
		input logic po
	);
		logic [15:0] c;
		c = po ? `TCC_IV_OVF : `TCC_IV_NONE;
		for (int i = NCH - 1; i >= 1; i--) begin
			if (pf[i]) begin
				c = 16'(2 * i); // lowest channel wins
			end
		end
		return c;
	endfunction : vec_code

	// enabled pending channel flags, channels 1 up
	function automatic logic [NCH-1:0] vec_pend(
		input tcc_state_t s
	);
		logic [NCH-1:0] p;
		p = '0;
		for (int i = 1; i < NCH; i++) begin
			p[i] = s.ch[i].flag & s.ch[i].ie; // disabled ignored
		end
		return p;
	endfunction : vec_pend

	// capture source select
	function automatic logic src_level(
		input tcc_pkg::tcc_ch_t c
	);
		logic l;
		l = 1'b0;
		unique case (c.in_sel)
			`TCC_SEL_A: l = c.filt_a;
			`TCC_SEL_B: l = c.filt_b;
			`TCC_SEL_LOW: l = 1'b0;
			`TCC_SEL_HIGH: l = 1'b1;
		endcase
		return l;
	endfunction : src_level

	// ****************************************
	// reset release
	// ****************************************

	// two stage reset release
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ****************************************
	// next state
	// ****************************************

	// channels, vector and read data
	always_comb begin
		logic [15:0] code;
		logic [7:0] ctl_a;
		logic [7:0] ccr_a;
		logic iv_hit;
		logic src;
		logic rise;
		logic fall;
		logic trig;
		logic cap_evt;
		logic m;
		logic pm;
		logic ccr_rd;
		logic [2:0] md;
		code = vec_code(vec_pend(state_reg),
			state_reg.ovf_flag & state_reg.ovf_ie);
		ctl_a = 8'h00;
		ccr_a = 8'h00;
		src = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		trig = 1'b0;
		cap_evt = 1'b0;
		m = 1'b0;
		ccr_rd = 1'b0;
		md = 3'h0;
		iv_hit = (bus.wr | bus.rd) && bus.addr == `TCC_IV_ADDR;
		state_next = state_reg;
		state_next.rdata = 16'h0000;
		state_next.match = '0;
		// period match from channel 0 compare value
		pm = I_COUNT_TICK
			&& I_TIMER_COUNT == state_reg.ch[0].ccr;
		state_next.pmatch = pm;

		// overflow control word
		if (bus.wr && bus.addr == `TCC_OVF_ADDR) begin
			state_next.ovf_flag = bus.wdata[`TCC_F_OVF_FLAG];
			state_next.ovf_ie = bus.wdata[`TCC_F_OVF_IE];
		end
		if (bus.rd && bus.addr == `TCC_OVF_ADDR) begin
			state_next.rdata[`TCC_F_OVF_FLAG] = state_reg.ovf_flag;
			state_next.rdata[`TCC_F_OVF_IE] = state_reg.ovf_ie;
		end
		// vector read answers the current code
		if (bus.rd && bus.addr == `TCC_IV_ADDR) begin
			state_next.rdata = code;
		end
		// vector access clears highest pending flag
		if (iv_hit && code == `TCC_IV_OVF) begin
			state_next.ovf_flag = 1'b0;
		end

		for (int i = 0; i < NCH; i++) begin
			ctl_a = 8'(`TCC_CTL_BASE + i * `TCC_STRIDE);
			ccr_a = 8'(`TCC_CCR_BASE + i * `TCC_STRIDE);
			// three stage input synchronisers
			state_next.ch[i].sync_a = {state_reg.ch[i].sync_a[1:0],
				I_INPUT_A[i]};
			state_next.ch[i].sync_b = {state_reg.ch[i].sync_b[1:0],
				I_INPUT_B[i]};
			// accept a level once stages two and three agree
			if (state_reg.ch[i].sync_a[1] == state_reg.ch[i].sync_a[2]) begin
				state_next.ch[i].filt_a = state_reg.ch[i].sync_a[2];
			end
			if (state_reg.ch[i].sync_b[1] == state_reg.ch[i].sync_b[2]) begin
				state_next.ch[i].filt_b = state_reg.ch[i].sync_b[2];
			end

			// edge detect on the selected source
			src = src_level(state_reg.ch[i]);
			rise = src & ~state_reg.ch[i].prev_src;
			fall = ~src & state_reg.ch[i].prev_src;
			state_next.ch[i].prev_src = src;
			unique case (state_reg.ch[i].edge_sel)
				`TCC_EDGE_RISE: trig = rise;
				`TCC_EDGE_FALL: trig = fall;
				`TCC_EDGE_BOTH: trig = rise | fall;
				default: trig = 1'b0;
			endcase
			// sync_capture holds the event one clock
			state_next.ch[i].pend = state_reg.ch[i].cap
				& state_reg.ch[i].scs & trig;
			cap_evt = state_reg.ch[i].cap & (state_reg.ch[i].scs ?
				state_reg.ch[i].pend : trig);
			// compare match while counting
			m = I_COUNT_TICK && !state_reg.ch[i].cap
				&& I_TIMER_COUNT == state_reg.ch[i].ccr;
			state_next.match[i] = m;

			// register reads
			if (bus.rd && bus.addr == ctl_a) begin
				state_next.rdata = {state_reg.ch[i].edge_sel,
					state_reg.ch[i].in_sel, state_reg.ch[i].scs,
					state_reg.ch[i].latched, 1'b0, state_reg.ch[i].cap,
					state_reg.ch[i].mode, state_reg.ch[i].ie,
					src, state_reg.ch[i].out,
					state_reg.ch[i].cov, state_reg.ch[i].flag};
			end
			ccr_rd = bus.rd && bus.addr == ccr_a;
			if (ccr_rd) begin
				state_next.rdata = state_reg.ch[i].ccr;
				state_next.ch[i].unread = 1'b0;
			end

			// software writes
			if (bus.wr && bus.addr == ctl_a) begin
				state_next.ch[i].edge_sel = bus.wdata[`TCC_F_EDGE +: 2];
				state_next.ch[i].in_sel = bus.wdata[`TCC_F_INSEL +: 2];
				state_next.ch[i].scs = bus.wdata[`TCC_F_SCS];
				state_next.ch[i].cap = bus.wdata[`TCC_F_CAP];
				state_next.ch[i].mode = bus.wdata[`TCC_F_MODE +: 3];
				state_next.ch[i].ie = bus.wdata[`TCC_F_IE];
				state_next.ch[i].out = bus.wdata[`TCC_F_OUT];
				state_next.ch[i].cov = bus.wdata[`TCC_F_COV];
				state_next.ch[i].flag = bus.wdata[`TCC_F_FLAG];
			end
			if (bus.wr && bus.addr == ccr_a) begin
				state_next.ch[i].ccr = bus.wdata;
			end

			// automatic clears, before hardware sets
			if (i == 0 && I_CH0_ACK) begin
				state_next.ch[i].flag = 1'b0;
			end
			if (i != 0 && iv_hit && code == 16'(2 * i)) begin
				state_next.ch[i].flag = 1'b0;
			end

			// capture event
			if (cap_evt) begin
				state_next.ch[i].ccr = I_TIMER_COUNT;
				state_next.ch[i].flag = 1'b1;
				state_next.ch[i].unread = 1'b1;
				if (state_reg.ch[i].unread && !ccr_rd) begin
					state_next.ch[i].cov = 1'b1;
				end
			end

			// compare event
			if (m) begin
				state_next.ch[i].flag = 1'b1;
				state_next.ch[i].latched = src;
			end

			// output unit, acts on the clock edge
			md = state_reg.ch[i].mode;
			unique case (md)
				`TCC_OM_OUTBIT: begin
				end
				`TCC_OM_SET: begin
					if (m) state_next.ch[i].out = 1'b1;
				end
				`TCC_OM_TOG_RST: begin
					if (m) state_next.ch[i].out = ~state_reg.ch[i].out;
					else if (pm) state_next.ch[i].out = 1'b0;
				end
				`TCC_OM_SET_RST: begin
					if (m) state_next.ch[i].out = 1'b1;
					else if (pm) state_next.ch[i].out = 1'b0;
				end
				`TCC_OM_TOGGLE: begin
					if (m) state_next.ch[i].out = ~state_reg.ch[i].out;
				end
				`TCC_OM_RESET: begin
					if (m) state_next.ch[i].out = 1'b0;
				end
				`TCC_OM_TOG_SET: begin
					if (m) state_next.ch[i].out = ~state_reg.ch[i].out;
					else if (pm) state_next.ch[i].out = 1'b1;
				end
				`TCC_OM_RST_SET: begin
					if (m) state_next.ch[i].out = 1'b0;
					else if (pm) state_next.ch[i].out = 1'b1;
				end
			endcase
		end

		// overflow event wins over any clear
		if (I_OVERFLOW) begin
			state_next.ovf_flag = 1'b1;
		end

		// interrupt requests from the new flags
		state_next.irq0 = state_next.ch[0].flag & state_next.ch[0].ie
			& I_GLOBAL_IRQ_EN;
		state_next.irqv = (|vec_pend(state_next)
			| (state_next.ovf_flag & state_next.ovf_ie))
			& I_GLOBAL_IRQ_EN;
	end

	// ****************************************
	// state register
	// ****************************************

	// all block state
	always_ff @(posedge I_REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************

	// flop driven outputs
	always_comb begin
		O_RDATA = state_reg.rdata;
		O_IRQ_CH0 = state_reg.irq0;
		O_IRQ_VEC = state_reg.irqv;
		O_CH_MATCH = state_reg.match;
		O_PERIOD_MATCH = state_reg.pmatch;
		for (int i = 0; i < NCH; i++) begin
			O_CH_OUT[i] = state_reg.ch[i].out;
		end
	end

endmodule : tcc_top
`default_nettype wire

//--- tb/tcc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module tcc_monitor #(
	parameter int NCH = 5
) (
	// clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_RESETN,
	// inputs watched
	input wire logic I_WR,
	input wire logic I_COUNT_TICK,
	input wire logic I_GLOBAL_IRQ_EN,
	// outputs watched
	input wire logic O_IRQ_CH0,
	input wire logic O_IRQ_VEC,
	input wire logic [NCH-1:0] O_CH_OUT,
	input wire logic [NCH-1:0] O_CH_MATCH,
	input wire logic O_PERIOD_MATCH
);
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RESETN);
	// ****
	// request gating, match pulses, output causes
	// ****
	a_irq0_gated: assert property (O_IRQ_CH0 |-> $past(I_GLOBAL_IRQ_EN))
		else $error("ch0 request without global enable");
	a_vec_gated: assert property (O_IRQ_VEC |-> $past(I_GLOBAL_IRQ_EN))
		else $error("vector request without global enable");
	a_match_ticked: assert property ((|O_CH_MATCH) |-> $past(I_COUNT_TICK))
		else $error("channel match without a counting tick");
	a_period_ticked: assert property (O_PERIOD_MATCH |-> $past(I_COUNT_TICK))
		else $error("period match without a counting tick");
	a_match_single: assert property ((O_CH_MATCH & $past(O_CH_MATCH)) == '0)
		else $error("channel match longer than one cycle");
	a_period_single: assert property (O_PERIOD_MATCH |=> !O_PERIOD_MATCH)
		else $error("period match longer than one cycle");
	a_ch0_period: assert property (O_CH_MATCH[0] |-> O_PERIOD_MATCH)
		else $error("ch0 match without period match");
	a_out_cause: assert property ($changed(O_CH_OUT) |->
		$past(I_WR) || (|O_CH_MATCH) || O_PERIOD_MATCH)
		else $error("output moved without write or match");
	// main scenarios reached
	c_ch_match: cover property (|O_CH_MATCH);
	c_period: cover property (O_PERIOD_MATCH);
	c_irq_vec: cover property (O_IRQ_VEC);
endmodule : tcc_monitor
bind tcc_top tcc_monitor #(.NCH(NCH)) u_tcc_monitor (.I_REF_CLK(I_REF_CLK),
	.I_RESETN(I_RESETN), .I_WR(I_WR), .I_COUNT_TICK(I_COUNT_TICK),
	.I_GLOBAL_IRQ_EN(I_GLOBAL_IRQ_EN), .O_IRQ_CH0(O_IRQ_CH0), .O_IRQ_VEC(O_IRQ_VEC),
	.O_CH_OUT(O_CH_OUT), .O_CH_MATCH(O_CH_MATCH), .O_PERIOD_MATCH(O_PERIOD_MATCH));
`default_nettype wire

//--- tb/tcc_counter.sv
`timescale 1ns/10ps
`default_nettype none
module tcc_counter (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// count control
	input wire logic i_run,
	input wire logic i_updown,
	input wire logic [15:0] i_period,
	input wire logic i_load,
	input wire logic [15:0] i_load_val,
	// count outputs
	output logic [15:0] o_count,
	output logic o_tick,
	output logic o_overflow
);
	logic down_reg;
	// up or up/down counting; a direct load never ticks
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_count <= 16'h0000;
			down_reg <= 1'b0;
			o_tick <= 1'b0;
			o_overflow <= 1'b0;
		end else begin
			o_tick <= i_run && !i_load;
			o_overflow <= 1'b0;
			if (i_load) begin
				o_count <= i_load_val;
				down_reg <= 1'b0;
			end else if (i_run && !i_updown) begin
				o_count <= o_count >= i_period ? 16'h0000 : o_count + 16'h0001;
				o_overflow <= o_count >= i_period;
			end else if (i_run && (down_reg || o_count >= i_period)) begin
				o_count <= o_count - 16'h0001;
				down_reg <= o_count != 16'h0001;
				o_overflow <= o_count == 16'h0001;
			end else if (i_run) begin
				o_count <= o_count + 16'h0001;
			end
		end
	end
endmodule : tcc_counter
`default_nettype wire

//--- tb/tcc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tcc_top_tb;
	localparam int NCH = 5;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, global_irq_enable = 1'b0, ack = 1'b0;
	logic run = 1'b0, updn = 1'b0, load = 1'b0, tick, ovf, irq0, irqv, pm;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000, per = 16'h0000, lval = 16'h0000, rdata, cnt;
	logic [NCH-1:0] in_a = '0, in_b = '0, chout, chm;
	int n_errors = 0, checks_done = 0;
	// ****
	// clock, design, counter model
	// ****
	always #10 clk = ~clk;
	tcc_top #(.NCH(NCH)) u_tcc_top (.I_REF_CLK(clk), .I_RESETN(rst_n), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TIMER_COUNT(cnt),
		.I_COUNT_TICK(tick), .I_OVERFLOW(ovf), .I_GLOBAL_IRQ_EN(global_irq_enable), .I_CH0_ACK(ack),
		.O_IRQ_CH0(irq0), .O_IRQ_VEC(irqv), .I_INPUT_A(in_a), .I_INPUT_B(in_b),
		.O_CH_OUT(chout), .O_CH_MATCH(chm), .O_PERIOD_MATCH(pm));
	tcc_counter u_tcc_counter (.i_clk(clk), .i_rst_n(rst_n), .i_run(run), .i_updown(updn),
		.i_period(per), .i_load(load), .i_load_val(lval), .o_count(cnt), .o_tick(tick),
		.o_overflow(ovf));
	// ****
	// bus tasks, compare, expectations
	// ****
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wrw(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wrw
	task automatic rdw(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rdw
	task automatic rc(input logic [7:0] a, input logic [15:0] e, input string nm);
		logic [15:0] d;
		rdw(a, d);
		chk(nm, e, d);
	endtask : rc
	// direct count write, no tick
	task automatic ld(input logic [15:0] v);
		@(posedge clk);
		lval <= v;
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
	endtask : ld
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out
	function automatic logic f_out(input logic [2:0] m, input logic o, c, p);
		case (m)
			3'h1: return c | o;
			3'h2: return c ? ~o : (o & ~p);
			3'h3: return c | (o & ~p);
			3'h4: return o ^ c;
			3'h5: return o & ~c;
			3'h6: return c ? ~o : (o | p);
			3'h7: return ~c & (o | p);
			default: return o;
		endcase
	endfunction : f_out
	function automatic logic [15:0] f_vec(input logic [4:0] h);
		for (int i = 0; i < 5; i++) begin
			if (h[i]) return 16'(2 * i + 2);
		end
		return 16'h0000;
	endfunction : f_vec
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		close_out();
	end
	// main sequence
	initial begin
		logic [15:0] d, p, c, cv;
		logic [4:0] fl, ie, hit;
		logic [1:0] e;
		logic o, t;
		d = 16'($urandom(55465));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		in_b <= NCH'($urandom);
		repeat (3) @(posedge clk);
		for (int i = 0; i < NCH; i++) begin
			rc(8'(2 * i), 16'h0000, "ctl reset");
			rc(8'(16 + 2 * i), 16'h0000, "ccr reset");
			d = 16'($urandom);
			wrw(8'(16 + 2 * i), d);
			rc(8'(16 + 2 * i), d, "ccr write");
		end
		rc(8'h20, 16'h0000, "vector reset");
		wrw(8'h30, 16'hffff);
		rc(8'h30, 16'h0000, "hole");
		// channel 4 watches input b, level must follow that pin
		wrw(8'h08, 16'h1000);
		rc(8'h08, {12'h100, in_b[4], 3'h0}, "level b");
		$display("test registers done");
		cv = 16'($urandom);
		ld(cv);
		for (int s = 0; s < 4; s++) begin
			wrw(8'h06, s[0] ? 16'hf900 : 16'he900);
			repeat (8) @(posedge clk);
			if (s == 1) rc(8'h16, cv, "sw capture word");
		end
		rc(8'h06, 16'hf90b, "overrun");
		rc(8'h16, cv, "second word");
		rc(8'h06, 16'hf90b, "overrun held");
		for (int i = 0; i < 4; i++) begin
			e = 2'(i + 1);
			wrw(8'h04, {e, 14'h0100});
			@(posedge clk);
			in_a[2] <= ~in_a[2];
			repeat (8) @(posedge clk);
			rdw(8'h04, d);
			chk("edge flag", 16'(in_a[2] ? e[0] : e[1]), 16'(d[0]));
		end
		$display("test capture done");
		p = 16'(6 + $urandom % 8);
		c = 16'(1 + $urandom % (p - 1));
		@(posedge clk);
		per <= p;
		in_a[1] <= 1'($urandom);
		wrw(8'h10, p);
		wrw(8'h12, c);
		for (int u = 0; u < 2; u++) begin
			@(posedge clk);
			updn <= u[0];
			ld(16'h0000);
			for (int m = 0; m < 8; m++) begin
				o = 1'($urandom);
				wrw(8'h02, {8'h00, 3'h7, 2'b00, o, 2'b00});
				wrw(8'h02, {8'h00, 3'(m), 2'b00, o, 2'b00});
				chk("out written", 16'(o), 16'(chout[1]));
				@(posedge clk);
				run <= 1'b1;
				repeat (2 * p + 4) begin
					@(negedge clk);
					cv = cnt;
					t = tick;
					@(posedge clk);
					#1 o = f_out(3'(m), o, t && cv == c, t && cv == p);
					chk("out", 16'(o), 16'(chout[1]));
					chk("match", 16'(t && cv == c), 16'(chm[1]));
					chk("period", 16'(t && cv == p), 16'(pm));
				end
				rdw(8'h02, d);
				chk("compare ctl", {5'h00, in_a[1], 2'b00, 3'(m), 1'b0, in_a[1], 3'b001},
					d & 16'hfffb);
				@(posedge clk);
				run <= 1'b0;
				repeat (2) @(posedge clk);
			end
		end
		// direct write of the compare value while counting must not match
		@(posedge clk);
		run <= 1'b1;
		ld(c);
		@(posedge clk);
		#1 chk("load no match", 16'h0000, 16'(chm[1]));
		@(posedge clk);
		run <= 1'b0;
		repeat (2) @(posedge clk);
		$display("test compare done");
		@(posedge clk);
		global_irq_enable <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			ie = k == 0 ? 5'h1f : 5'($urandom);
			fl = 5'($urandom);
			for (int i = 0; i < 4; i++) wrw(8'(2 + 2 * i), {11'h000, ie[i], 3'h0, fl[i]});
			wrw(8'h22, {14'h0000, ie[4], fl[4]});
			for (int j = 0; j < 6; j++) begin
				hit = fl & ie;
				if (j == 2) wrw(8'h20, 16'h0000);
				else rc(8'h20, f_vec(hit), "vector");
				fl = fl & ~(hit & (~hit + 5'h01));
				chk("vector request", 16'(|(fl & ie)), 16'(irqv));
			end
		end
		wrw(8'h02, 16'h0011);
		wrw(8'h00, 16'h0011);
		chk("ch0 request", 16'h0001, 16'(irq0));
		@(posedge clk);
		global_irq_enable <= 1'b0;
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("gated", 16'h0000, 16'(irqv));
		chk("ch0 gated", 16'h0000, 16'(irq0));
		rc(8'h00, 16'h0010, "ch0 serviced");
		rc(8'h02, 16'h0011 | {5'h00, in_a[1], 6'h00, in_a[1], 3'h0}, "ch1 kept");
		$display("test interrupts done");
		close_out();
	end
endmodule : tcc_top_tb
`default_nettype wire
